// ==== sebs_eeprom_slave.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Summary of operation
// [RQ1] No acknowledge during internal write cycle
// [RQ2] Programming starts at stop ending write
// [RQ3] Data line released while write runs
// [RQ4] Short clock and data pulses rejected
// [RQ5] Address: type, block/select bits, direction
// [RQ6] Type field must equal class code
// [RQ7] Select bit must equal strap pin
// [RQ8] Block bits choose a 256-byte block
// [RQ9] Direction one reads, zero writes
// [RQ10] Receiver pulls data low on ninth clock
// [RQ11] Array address follows acknowledged slave address
// [RQ12] Array address picks one of 256
// [RQ13] Page is 16 aligned bytes
// [RQ14] Block holds 16 pages of 16
// [RQ15] Master starts, sends bytes, stops
// [RQ16] Each received byte acknowledged to continue
// [RQ17] Master sends address fields in order
// [RQ18] Master keeps bus free before start
// [RQ19] Master holds clock after start
// [RQ20] Master holds clock before repeated start
// [RQ21] Master holds clock before stop
// [RQ22] Nothing happens until a start
// [RQ23] Data changes only while clock low
// [RQ24] Read stops sending on missing acknowledge
// [RQ25] Unstrapped select bits choose page block
// [RQ26] Counter times write cycle, blocks matching
// [RQ27] Inputs synchronised before edge detection
// ----------------------------------------------------------------------
module sebs_eeprom_slave
  import sebs_pkg::*;
#(
  parameter int unsigned TWR_CYC   = SEBS_TWR_CYC, // Write cycle in cycles
  parameter bit          FAST_MODE = 1'b0,         // Narrower glitch filter
  parameter logic [3:0]  TYPE_CODE = 4'h5          // Arbitrary class code
)(
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  input  wire logic select_strap_pin,
  output logic      write_busy
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  localparam int unsigned TW = $clog2(TWR_CYC + 1);
  localparam int unsigned HOLD_CYC =
    FAST_MODE ? SEBS_TI_FAST_CYC : SEBS_TI_STD_CYC;

  // Refuse a write cycle the timer cannot serve
  if (TWR_CYC < 1) begin : g_bad_twr
    $error("write cycle must last at least one cycle");
  end

  sebs_line_if lines ();

  sebs_state_e          state_q;     // Protocol state
  logic [3:0]           bit_cnt_q;   // Clock rises seen in this byte
  logic [7:0]           shift_q;     // Received byte
  logic [7:0]           tx_q;        // Byte being sent
  logic [SEBS_AW-1:0]   addr_q;      // Full byte address
  logic                 rd_mode_q;   // Current access reads
  logic                 rd_ack_q;    // Master acknowledged last byte
  logic                 sda_oe_q;    // Pulling the data line low
  logic                 sda_o_q;     // Driven level, always low
  logic                 busy_q;      // Internal write cycle running
  logic [TW-1:0]        twr_cnt_q;   // Cycles left in write cycle
  logic [15:0]          mask_q;      // Page buffer bytes written
  logic [5:0]           page_q;      // Page being buffered
  logic [7:0]           buf_q [SEBS_PAGE_BYTES];  // Page buffer
  logic [7:0]           mem_q [SEBS_MEM_BYTES];   // Storage array
  logic [7:0]           mem_rd;      // Byte at current address
  logic                 dev_match;   // Slave address is ours
  logic                 byte_done;   // Eighth bit taken, clock fell
  logic                 cap_byte;    // Data byte into page buffer
  logic                 commit;      // Stop ends a write sequence

  // ----------------------------------------------------------------------
  // Line conditioning
  // ----------------------------------------------------------------------
  sebs_glitch_filter #(
    .HOLD_CYC (HOLD_CYC)
  ) u_filter (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .strap_i (select_strap_pin),
    .lines   (lines.filt)
  );

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  // [RQ6] [RQ7] type and strap compare
  assign dev_match = (shift_q[SEBS_TYPE_MSB:SEBS_TYPE_LSB] == TYPE_CODE)
                  && (shift_q[SEBS_STRAP_BIT] == lines.strap);
  assign byte_done = lines.scl_fall && (bit_cnt_q == SEBS_BITS_PER_BYTE);
  assign cap_byte  = !busy_q && !lines.stop && !lines.start
                  && (state_q == SEBS_WRDATA) && byte_done;
  // [RQ2] Stop after written data
  assign commit    = lines.stop && !busy_q && (|mask_q);
  assign mem_rd    = mem_q[addr_q];

  // ----------------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------------
  // Byte sequencing, address capture and data line drive
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q   <= SEBS_IDLE;
      bit_cnt_q <= '0;
      shift_q   <= '0;
      tx_q      <= '0;
      addr_q    <= '0;
      rd_mode_q <= 1'h0;
      rd_ack_q  <= 1'h0;
      sda_oe_q  <= 1'h0;
    end else if (busy_q) begin
      // [RQ1] [RQ3] interface dead while programming
      state_q  <= SEBS_IDLE;
      sda_oe_q <= 1'h0;
    end else if (lines.stop) begin
      state_q  <= SEBS_IDLE;
      sda_oe_q <= 1'h0;
    end else if (lines.start) begin
      // [RQ22] only a start opens a command
      state_q   <= SEBS_DEVADDR;
      bit_cnt_q <= '0;
      sda_oe_q  <= 1'h0;
    end else begin
      case (state_q)
        // Receiving a byte, MSB first on each clock rise
        SEBS_DEVADDR, SEBS_ARRADDR, SEBS_WRDATA: begin
          if (lines.scl_rise && bit_cnt_q != SEBS_BITS_PER_BYTE) begin
            shift_q   <= {shift_q[6:0], lines.sda};
            bit_cnt_q <= bit_cnt_q + 1'b1;
          end else if (byte_done) begin
            bit_cnt_q <= '0;
            if (state_q == SEBS_DEVADDR) begin
              // [RQ5] field split of slave address
              if (dev_match) begin
                // [RQ10] pull low for ninth clock
                state_q   <= SEBS_DEVACK;
                sda_oe_q  <= 1'h1;
                // [RQ8] [RQ25] block bits into address
                addr_q[SEBS_AW-1 -: 2] <=
                  shift_q[SEBS_PB_HI_BIT:SEBS_PB_LO_BIT];
                // [RQ9] direction bit
                rd_mode_q <= (shift_q[SEBS_DIR_BIT] == SEBS_DIR_READ);
              end else begin
                // Not ours: stay silent until the next start
                state_q <= SEBS_WAITSTOP;
              end
            end else if (state_q == SEBS_ARRADDR) begin
              // [RQ11] [RQ12] byte within block
              addr_q[7:0] <= shift_q;
              state_q     <= SEBS_ADDRACK;
              sda_oe_q    <= 1'h1;
            end else begin
              // [RQ16] acknowledge each data byte
              state_q  <= SEBS_WRACK;
              sda_oe_q <= 1'h1;
            end
          end
        end
        // End of ninth clock after the slave address
        SEBS_DEVACK: begin
          if (lines.scl_fall) begin
            if (rd_mode_q) begin
              // Current address read: first bit out at once
              state_q  <= SEBS_RDDATA;
              tx_q     <= {mem_rd[6:0], 1'b0};
              sda_oe_q <= !mem_rd[7];
            end else begin
              state_q  <= SEBS_ARRADDR;
              sda_oe_q <= 1'h0;
            end
          end
        end
        // Release after the array address acknowledge
        SEBS_ADDRACK: begin
          if (lines.scl_fall) begin
            state_q  <= SEBS_WRDATA;
            sda_oe_q <= 1'h0;
          end
        end
        // [RQ13] address rolls within the page
        SEBS_WRACK: begin
          if (lines.scl_fall) begin
            state_q     <= SEBS_WRDATA;
            sda_oe_q    <= 1'h0;
            addr_q[3:0] <= addr_q[3:0] + 1'b1;
          end
        end
        // [RQ23] data changes on clock fall only
        SEBS_RDDATA: begin
          if (lines.scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 1'b1;
          end else if (byte_done) begin
            state_q   <= SEBS_RDACK;
            bit_cnt_q <= '0;
            sda_oe_q  <= 1'h0;
          end else if (lines.scl_fall) begin
            sda_oe_q <= !tx_q[7];
            tx_q     <= {tx_q[6:0], 1'b0};
          end
        end
        // [RQ24] master acknowledge decides
        SEBS_RDACK: begin
          if (lines.scl_rise) begin
            rd_ack_q <= !lines.sda;
            if (!lines.sda) begin
              addr_q <= addr_q + 1'b1;
            end
          end else if (lines.scl_fall) begin
            if (rd_ack_q) begin
              state_q  <= SEBS_RDDATA;
              tx_q     <= {mem_rd[6:0], 1'b0};
              sda_oe_q <= !mem_rd[7];
            end else begin
              state_q <= SEBS_WAITSTOP;
            end
          end
        end
        // Idle or waiting for a stop: bus left alone
        default: begin
          sda_oe_q <= 1'h0;
        end
      endcase
    end
  end

  // Open-drain output only ever drives low
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sda_o_q <= 1'h0;
    end else begin
      sda_o_q <= 1'h0;
    end
  end

  // ----------------------------------------------------------------------
  // Write cycle timer
  // ----------------------------------------------------------------------
  // [RQ26] busy counts down from the stop
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      busy_q    <= 1'h0;
      twr_cnt_q <= '0;
    end else if (commit) begin
      busy_q    <= 1'h1;
      twr_cnt_q <= TW'(TWR_CYC - 1);
    end else if (busy_q) begin
      if (twr_cnt_q == '0) begin
        busy_q <= 1'h0;
      end else begin
        twr_cnt_q <= twr_cnt_q - 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Page buffer and array
  // ----------------------------------------------------------------------
  // Which bytes of the page wait for programming
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mask_q <= '0;
      page_q <= '0;
    end else if (commit || (lines.start && !busy_q)) begin
      mask_q <= '0;
    end else if (cap_byte) begin
      mask_q[addr_q[3:0]] <= 1'h1;
      page_q              <= addr_q[SEBS_AW-1:4];
    end
  end

  // [RQ14] storage stays data; no reset
  always_ff @(posedge ref_clk) begin
    if (cap_byte) begin
      buf_q[addr_q[3:0]] <= shift_q;
    end
    if (commit) begin
      for (int i = 0; i < SEBS_PAGE_BYTES; i++) begin
        if (mask_q[i]) begin
          mem_q[{page_q, 4'(i)}] <= buf_q[i];
        end
      end
    end
  end

  assign sda_o      = sda_o_q;
  assign sda_oe     = sda_oe_q;
  assign write_busy = busy_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  busy_quiet_a: assert property (busy_q |=> !sda_oe_q) // [RQ3]
    else $error("data line driven during write cycle");
  busy_no_ack_a: assert property ( // [RQ1]
    busy_q && lines.start |=> state_q == SEBS_IDLE [*3])
    else $error("start accepted during write cycle");
  stop_commit_a: assert property ( // [RQ2]
    lines.stop && !busy_q && (|mask_q) |=> busy_q && mask_q == '0)
    else $error("stop after write did not start programming");
  timer_len_a: assert property ( // [RQ26]
    $rose(busy_q) |-> twr_cnt_q == TW'(TWR_CYC - 1))
    else $error("write timer loaded with wrong count");
  type_miss_a: assert property ( // [RQ6]
    state_q == SEBS_DEVADDR && byte_done && !lines.stop && !busy_q
    && !lines.start && shift_q[7:4] != TYPE_CODE
    |=> state_q == SEBS_WAITSTOP && !sda_oe_q)
    else $error("foreign type code acknowledged");
  strap_miss_a: assert property ( // [RQ7]
    state_q == SEBS_DEVADDR && byte_done && !lines.stop && !busy_q
    && !lines.start && shift_q[3] != lines.strap
    |=> state_q != SEBS_DEVACK)
    else $error("strap mismatch acknowledged");
  ninth_ack_a: assert property ( // [RQ10]
    state_q == SEBS_DEVACK |-> sda_oe_q)
    else $error("address acknowledge not driven");
  dir_sel_a: assert property ( // [RQ9]
    $rose(state_q == SEBS_DEVACK) |-> rd_mode_q == $past(shift_q[0]))
    else $error("direction bit decoded wrongly");
  page_roll_a: assert property ( // [RQ13]
    state_q == SEBS_WRACK && lines.scl_fall && !busy_q && !lines.stop
    && !lines.start |=> addr_q[9:4] == $past(addr_q[9:4]))
    else $error("write address left its page");
  rd_nack_a: assert property ( // [RQ24]
    state_q == SEBS_RDACK && lines.scl_fall && !rd_ack_q && !busy_q
    && !lines.stop && !lines.start |=> state_q == SEBS_WAITSTOP)
    else $error("read continued without acknowledge");
  need_start_a: assert property ( // [RQ22]
    state_q == SEBS_IDLE && !lines.start |=> state_q == SEBS_IDLE)
    else $error("left idle without a start");

  write_seen_c: cover property ($rose(busy_q));
  read_seen_c:  cover property (state_q == SEBS_RDACK && rd_ack_q);
  miss_seen_c:  cover property (state_q == SEBS_WAITSTOP);

endmodule : sebs_eeprom_slave

// ==== sebs_pkg.sv ====
// ----------------------------------------------------------------------
// Shared constants of the serial EEPROM bus slave
// ----------------------------------------------------------------------
package sebs_pkg;

  // Timebase of the device logic
  localparam int unsigned SEBS_CLK_HZ       = 25_000_000;
  localparam int unsigned SEBS_CLK_NS       = 40;

  // Write cycle time, upper and lower supply range, in ms
  localparam int unsigned SEBS_TWR_MS       = 10;
  localparam int unsigned SEBS_TWR_LO_MS    = 15;
  // Longest times round down to whole cycles
  localparam int unsigned SEBS_TWR_CYC      =
    SEBS_TWR_MS * (SEBS_CLK_HZ / 1000);
  localparam int unsigned SEBS_TWR_LO_CYC   =
    SEBS_TWR_LO_MS * (SEBS_CLK_HZ / 1000);

  // Noise suppression width in ns, standard and fast speed
  localparam int unsigned SEBS_TI_STD_NS    = 100;
  localparam int unsigned SEBS_TI_FAST_NS   = 50;
  // A level must hold longer than the width, so round up
  localparam int unsigned SEBS_TI_STD_CYC   =
    (SEBS_TI_STD_NS + SEBS_CLK_NS - 1) / SEBS_CLK_NS;
  localparam int unsigned SEBS_TI_FAST_CYC  =
    (SEBS_TI_FAST_NS + SEBS_CLK_NS - 1) / SEBS_CLK_NS;

  // Slave address byte layout
  localparam int unsigned SEBS_TYPE_MSB     = 7;
  localparam int unsigned SEBS_TYPE_LSB     = 4;
  localparam int unsigned SEBS_STRAP_BIT    = 3;
  localparam int unsigned SEBS_PB_HI_BIT    = 2;
  localparam int unsigned SEBS_PB_LO_BIT    = 1;
  localparam int unsigned SEBS_DIR_BIT      = 0;
  localparam logic        SEBS_DIR_READ     = 1'h1;

  // Array geometry: 4 page blocks of 16 pages of 16 bytes
  localparam int unsigned SEBS_PAGE_BYTES   = 16;
  localparam int unsigned SEBS_BLOCK_PAGES  = 16;
  localparam int unsigned SEBS_BLOCK_BYTES  = 256;
  localparam int unsigned SEBS_BLOCKS       = 4;
  localparam int unsigned SEBS_MEM_BYTES    = SEBS_BLOCKS * SEBS_BLOCK_BYTES;
  localparam int unsigned SEBS_AW           = 10;
  localparam logic [3:0]  SEBS_BITS_PER_BYTE = 4'h8;

  // Byte level protocol states
  typedef enum logic [3:0] {
    SEBS_IDLE, SEBS_DEVADDR, SEBS_DEVACK, SEBS_ARRADDR, SEBS_ADDRACK,
    SEBS_WRDATA, SEBS_WRACK, SEBS_RDDATA, SEBS_RDACK, SEBS_WAITSTOP
  } sebs_state_e;

endpackage : sebs_pkg

// ==== sebs_line_if.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Cleaned bus lines and bus events, filter to protocol core
// ----------------------------------------------------------------------
interface sebs_line_if;
  logic scl;       // Filtered clock line level
  logic sda;       // Filtered data line level
  logic strap;     // Synchronised strap level
  logic scl_rise;  // One-cycle pulse, clock line rose
  logic scl_fall;  // One-cycle pulse, clock line fell
  logic start;     // One-cycle pulse, data fell while clock high
  logic stop;      // One-cycle pulse, data rose while clock high
  modport filt (output scl, sda, strap, scl_rise, scl_fall, start, stop);
  modport core (input  scl, sda, strap, scl_rise, scl_fall, start, stop);
endinterface : sebs_line_if

// ==== sebs_glitch_filter.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Pin synchroniser, glitch filter and start/stop detector
// ----------------------------------------------------------------------
module sebs_glitch_filter
  import sebs_pkg::*;
#(
  parameter int unsigned HOLD_CYC = SEBS_TI_STD_CYC // Cycles a level must hold
)(
  input  wire logic   ref_clk,
  input  wire logic   resetn,
  input  wire logic   scl_i,
  input  wire logic   sda_i,
  input  wire logic   strap_i,
  sebs_line_if.filt   lines
);

  localparam int unsigned CW = $clog2(HOLD_CYC + 1);

  // Refuse a hold time the counter cannot express
  if (HOLD_CYC < 1) begin : g_bad_hold
    $error("hold cycles must be at least one");
  end

  logic [2:0] raw;     // Strap, data, clock as they arrive
  logic [2:0] level;   // Accepted levels
  logic       scl_p_q; // Previous accepted clock
  logic       sda_p_q; // Previous accepted data

  assign raw = {strap_i, sda_i, scl_i};

  // [RQ27] Two flops, then filter
  for (genvar i = 0; i < 3; i++) begin : g_pin
    logic          meta_q; // First stage, read only by sync_q
    logic          sync_q; // Second stage
    logic          lvl_q;  // Accepted level
    logic [CW-1:0] cnt_q;  // Cycles the new level has held
    // Synchroniser; idle bus lines are high
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        meta_q <= 1'h1;
        sync_q <= 1'h1;
      end else begin
        meta_q <= raw[i];
        sync_q <= meta_q;
      end
    end
    // [RQ4] Reject short pulses
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        lvl_q <= 1'h1;
        cnt_q <= '0;
      end else if (sync_q == lvl_q) begin
        cnt_q <= '0;
      end else if (cnt_q == CW'(HOLD_CYC - 1)) begin
        lvl_q <= sync_q;
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
    assign level[i] = lvl_q;
  end

  // Edge and condition detection on the clean levels
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      scl_p_q        <= 1'h1;
      sda_p_q        <= 1'h1;
      lines.scl_rise <= 1'h0;
      lines.scl_fall <= 1'h0;
      lines.start    <= 1'h0;
      lines.stop     <= 1'h0;
    end else begin
      scl_p_q        <= level[0];
      sda_p_q        <= level[1];
      lines.scl_rise <= level[0] & ~scl_p_q;
      lines.scl_fall <= ~level[0] & scl_p_q;
      // [RQ22] Data edges while clock high
      lines.start    <= level[0] & scl_p_q & sda_p_q & ~level[1];
      lines.stop     <= level[0] & scl_p_q & ~sda_p_q & level[1];
    end
  end

  assign lines.scl   = scl_p_q;
  assign lines.sda   = sda_p_q;
  assign lines.strap = level[2];

endmodule : sebs_glitch_filter

// ==== sebs_master_model.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Two-wire bus master model, open drain, timed by the link clock
// ----------------------------------------------------------------------
module sebs_master_model #(
  parameter int unsigned Q   = 4,  // Link cycles per quarter bit
  parameter int unsigned SU  = 30, // Clock high before start or stop, 4.8 us
  parameter int unsigned HD  = 26, // Clock high after start, 4.16 us
  parameter int unsigned BUF = 30  // Free bus after stop, 4.8 us
)(
  input  wire logic link_clk,
  input  wire logic sda_line,
  output logic      scl_low,
  output logic      sda_low
);
  // Idle bus: both lines released, clock stands still
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  task automatic tq(input int unsigned n);
    repeat (n) @(posedge link_clk);
  endtask : tq

  // data falls while clock high, clock held after
  task automatic bus_start();
    tq(Q); sda_low = 1'b0;
    tq(Q); scl_low = 1'b0;
    tq(SU); sda_low = 1'b1;
    tq(HD); scl_low = 1'b1;
  endtask : bus_start

  // clock held before stop, then bus left free
  task automatic bus_stop();
    tq(Q); sda_low = 1'b1;
    tq(Q); scl_low = 1'b0;
    tq(SU); sda_low = 1'b0;
    tq(BUF);
  endtask : bus_stop

  // data changes only while clock low, sampled while high
  task automatic bit_x(input logic b, output logic s);
    tq(Q); sda_low = ~b;
    tq(Q); scl_low = 1'b0;
    tq(Q); s = sda_line;
    tq(Q); scl_low = 1'b1;
  endtask : bit_x

  // MSB first, line released on ninth clock
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], s);
    end
    bit_x(1'b1, ack);
  endtask : put_byte

  // master acknowledges or withholds it to end the read
  task automatic get_byte(output logic [7:0] d, input logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, s);
      d[i] = s;
    end
    bit_x(nack, s);
  endtask : get_byte
endmodule : sebs_master_model

// ==== testbench.sv ====
`timescale 1ns/10ps
module testbench;
  import sebs_pkg::*;
  localparam int unsigned WRITE_CYCLE_TIME   = 3000;  // Shortened write cycle
  localparam logic [3:0]  TCODE = 4'h5;  // Arbitrary class code
  localparam int unsigned CEIL  = 80000; // Run ceiling in cycles
  logic ref_clk, link_clk, resetn, strap;
  logic sda_o, sda_oe, write_busy, scl_low, sda_low;
  logic scl_line, sda_line, oe_busy;
  logic scl_glitch; // Short spike forced onto the clock line
  int   fails, num_checks, cyc, busy_cnt;

  // Open-drain wires with pull-ups
  assign scl_line = ~scl_low | scl_glitch;
  assign sda_line = ~(sda_low | (sda_oe & ~sda_o));

  sebs_eeprom_slave #(.TWR_CYC(WRITE_CYCLE_TIME), .FAST_MODE(1'b0), .TYPE_CODE(TCODE))
    u_dut (.ref_clk(ref_clk), .resetn(resetn), .scl_i(scl_line),
           .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
           .select_strap_pin(strap), .write_busy(write_busy));
  sebs_master_model u_master (.link_clk(link_clk), .sda_line(sda_line),
                              .scl_low(scl_low), .sda_low(sda_low));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Link clock, phase unrelated to the device clock
  initial begin
    link_clk = 1'b0;
    #7;
    forever #80 link_clk = ~link_clk;
  end

  // Cycle ceiling, busy length and drive during busy
  always @(posedge ref_clk) begin
    cyc++;
    if (write_busy === 1'b1) busy_cnt++;
    if (write_busy === 1'b1 && sda_oe !== 1'b0) oe_busy = 1'b1;
    if (cyc == CEIL) begin
      fails++;
      summarize();
    end
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic wait_busy(logic v);
    for (int k = 0; k < WRITE_CYCLE_TIME + 500 && write_busy !== v; k++)
      @(posedge ref_clk);
  endtask : wait_busy

  // Address phase: slave address then array address
  task automatic addr_phase(logic [1:0] bb, logic [7:0] aa);
    logic ack;
    u_master.bus_start();
    // 80 ns clock spike while the clock is low must not count
    fork
      u_master.put_byte({TCODE, strap, bb, 1'b0}, ack);
      begin
        repeat (10) @(negedge ref_clk);
        scl_glitch = 1'b1;
        repeat (2) @(negedge ref_clk);
        scl_glitch = 1'b0;
      end
    join
    check("slave ack", ack, 1'b0);
    u_master.put_byte(aa, ack);
    check("array ack", ack, 1'b0);
  endtask : addr_phase

  // Write n bytes, then probe the device while it programs
  task automatic s_write(logic [1:0] bb, logic [7:0] aa, logic [7:0] d,
                         int n);
    logic ack;
    busy_cnt = 0;
    oe_busy  = 1'b0;
    addr_phase(bb, aa);
    for (int i = 0; i < n; i++) begin
      u_master.put_byte(d + 8'(i), ack);
      check("data ack", ack, 1'b0);
    end
    u_master.bus_stop();
    wait_busy(1'b1);
    check("busy rise", write_busy, 1'b1);
    u_master.bus_start();
    u_master.put_byte({TCODE, strap, bb, 1'b0}, ack);
    check("ack while busy", ack, 1'b1);
    u_master.bus_stop();
    wait_busy(1'b0);
    check("busy length", busy_cnt, WRITE_CYCLE_TIME);
    check("drive while busy", oe_busy, 1'b0);
  endtask : s_write

  // Random read after a dummy write of the array address
  task automatic s_read(logic [1:0] bb, logic [7:0] aa, logic [7:0] exp);
    logic       ack;
    logic [7:0] got;
    addr_phase(bb, aa);
    u_master.bus_start();
    u_master.put_byte({TCODE, strap, bb, 1'b1}, ack);
    check("read addr ack", ack, 1'b0);
    u_master.get_byte(got, 1'b1);
    // Past the filtered ninth fall, before the stop begins
    repeat (12) @(negedge ref_clk);
    check("quiet after nack", sda_oe, 1'b0);
    u_master.bus_stop();
    check("read data", got, exp);
  endtask : s_read

  // Foreign type code or wrong strap bit gets no acknowledge
  task automatic s_bad(logic [3:0] t, logic s);
    logic ack;
    u_master.bus_start();
    u_master.put_byte({t, s, 2'h0, 1'b0}, ack);
    u_master.bus_stop();
    check("foreign addr ack", ack, 1'b1);
  endtask : s_bad

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  initial begin
    resetn = 1'b0;
    strap  = 1'b1;
    scl_glitch = 1'b0;
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk) resetn = 1'b1;
    repeat (20) @(posedge ref_clk);
    s_write(2'h1, 8'h1f, 8'h3c, 2);
    s_write(2'h2, 8'h1f, 8'hc5, 1);
    s_read(2'h1, 8'h1f, 8'h3c);
    s_read(2'h1, 8'h10, 8'h3d);
    s_read(2'h2, 8'h1f, 8'hc5);
    s_bad(4'h3, 1'b1);
    s_bad(TCODE, 1'b0);
    @(negedge ref_clk) strap = 1'b0;
    repeat (20) @(posedge ref_clk);
    s_write(2'h3, 8'h00, 8'ha7, 1);
    s_read(2'h3, 8'h00, 8'ha7);
    summarize();
  end
endmodule : testbench
